// file: core/peak_hold_params.svh
// constants for the peak hold picker: register map, field positions,
// reset values and timing figures.
// assumes a 100 MHz system clock and 16-bit temperatures in 0.01 degree.
`ifndef PEAK_HOLD_PARAMS_SVH
`define PEAK_HOLD_PARAMS_SVH

// register word indexes, taken from byte address bits 5:2
`define PH_ADDR_CTRL     4'h0
`define PH_ADDR_THR      4'h1
`define PH_ADDR_DECAY    4'h2
`define PH_ADDR_DELAY    4'h3
`define PH_ADDR_LOWLIM   4'h4
`define PH_ADDR_STATUS   4'h5
`define PH_ADDR_LSB      2
`define PH_ADDR_MSB      5

// control fields
`define PH_MODE_LSB      0
`define PH_MODE_MSB      1
`define PH_CSEL_LSB      4
`define PH_CSEL_MSB      7
`define PH_CSEL_OFF      4'h0
`define PH_CSEL_AUTO     4'h1
`define PH_CSEL_MAX      4'hc

// reset values
`define PH_RST_CTRL      32'h0000_0000
`define PH_RST_TEMP      16'h0000

// timing: base tick of one millisecond
`define PH_CLK_NS        10
`define PH_TICK_NS       1000000
`define PH_DELAY_UNIT_MS 14'h000a
`define PH_DECAY_DIV     17'h003e8

// clear interval lengths in ms for selector codes 2 to 12
`define PH_CI_2          15'h000a
`define PH_CI_3          15'h0014
`define PH_CI_4          15'h0032
`define PH_CI_5          15'h0064
`define PH_CI_6          15'h00c8
`define PH_CI_7          15'h01f4
`define PH_CI_8          15'h03e8
`define PH_CI_9          15'h07d0
`define PH_CI_10         15'h1388
`define PH_CI_11         15'h2710
`define PH_CI_12         15'h61a8

// one degree in temperature units
`define PH_ONE_DEG       16'h0064

// bus answers
`define PH_RESP_OKAY     2'b00
`define PH_RESP_SLVERR   2'b10

`endif

// file: core/peak_hold_pkg.sv
// types shared by the peak hold picker.
// assumes peak_hold_params.svh for the numeric constants.
package peak_hold_pkg;

  typedef enum logic [1:0] {
    MODE_LIVE,
    MODE_AUTO,
    MODE_CLEAR,
    MODE_SMART
  } mode_e;

  typedef enum logic [1:0] {
    SM_BELOW,
    SM_DELAY,
    SM_HOLD
  } smart_e;

  typedef struct packed {
    logic        valid;
    logic [15:0] temp;
  } sample_s;

endpackage : peak_hold_pkg

// file: core/peak_hold_picker.sv
// peak hold picker with axi4-lite registers and a sample stream.
// assumes samples already pass the response filter and are synchronous.
`timescale 1ns/100ps
`default_nettype none
`include "peak_hold_params.svh"

module peak_hold_picker import peak_hold_pkg::*; #(
  parameter int TICK_CYCLES = `PH_TICK_NS / `PH_CLK_NS
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [31:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [31:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire sample_s     sampleIn,
  output sample_s          sampleOut
);

  logic [31:0] ctrl_q;
  logic [15:0] thr_q, decay_q, delay_q, lowLim_q;
  logic [3:0]  awIdx_q;
  logic        awHeld_q, wHeld_q;
  logic [31:0] wData_q;
  logic [3:0]  wStrb_q;
  logic [31:0] tickCnt_q;
  logic        tick;
  logic [14:0] ciCnt_q;
  logic [14:0] ciLen;
  logic [13:0] dlyCnt_q;
  logic [15:0] held_q, run_q, shown_q;
  logic        shownOk_q, prevHot_q;
  logic [9:0]  decAcc_q;
  logic [16:0] decSum;
  logic [16:0] decWhole;
  logic [15:0] decayed;
  logic [1:0]  modeLast_q;
  logic        modeChg;
  smart_e      sm_q;
  mode_e       mode;
  logic [3:0]  csel;
  logic        clearOn;
  logic        doWrite;
  logic [15:0] t;
  logic        hotNow;
  logic        newObj;

  // mode is a single 2-bit field, so two modes can never be on at once
  assign mode    = mode_e'(ctrl_q[`PH_MODE_MSB:`PH_MODE_LSB]);
  assign csel    = ctrl_q[`PH_CSEL_MSB:`PH_CSEL_LSB];
  assign clearOn = (mode == MODE_CLEAR) && (csel > `PH_CSEL_AUTO);
  assign modeChg = (modeLast_q != ctrl_q[`PH_MODE_MSB:`PH_MODE_LSB]);
  assign t       = sampleIn.temp; // already filtered upstream
  assign doWrite = awHeld_q && wHeld_q && !bvalid;

  // new hot object: at least one degree over the low limit, from not hot
  assign hotNow  = ({1'b0, t} >=
                    ({1'b0, lowLim_q} + {1'b0, `PH_ONE_DEG}));
  assign newObj  = sampleIn.valid && hotNow && !prevHot_q;

  // write address and data are accepted independently
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      awHeld_q <= 1'b0;
      wHeld_q  <= 1'b0;
      awIdx_q  <= 4'h0;
      wData_q  <= 32'h0000_0000;
      wStrb_q  <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        awHeld_q <= 1'b1;
        awIdx_q  <= awaddr[`PH_ADDR_MSB:`PH_ADDR_LSB];
      end else if (doWrite) begin
        awHeld_q <= 1'b0;
      end
      if (wvalid && wready) begin
        wHeld_q <= 1'b1;
        wData_q <= wdata;
        wStrb_q <= wstrb;
      end else if (doWrite) begin
        wHeld_q <= 1'b0;
      end
    end
  end

  // ready only while the channel has nothing pending
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      awready <= 1'b0;
      wready  <= 1'b0;
    end else begin
      awready <= !awHeld_q && !(awvalid && awready) && !bvalid;
      wready  <= !wHeld_q && !(wvalid && wready) && !bvalid;
    end
  end

  // register writes and the write response
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_q   <= `PH_RST_CTRL;
      thr_q    <= `PH_RST_TEMP;
      decay_q  <= `PH_RST_TEMP;
      delay_q  <= `PH_RST_TEMP;
      lowLim_q <= `PH_RST_TEMP;
      bvalid   <= 1'b0;
      bresp    <= `PH_RESP_OKAY;
    end else begin
      if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
      if (doWrite) begin
        bvalid <= 1'b1;
        bresp  <= `PH_RESP_OKAY;
        case (awIdx_q)
          `PH_ADDR_CTRL: begin
            if (wStrb_q[0]) ctrl_q[7:0] <= wData_q[7:0];
          end
          `PH_ADDR_THR: begin
            if (wStrb_q[0]) thr_q[7:0] <= wData_q[7:0];
            if (wStrb_q[1]) thr_q[15:8] <= wData_q[15:8];
          end
          `PH_ADDR_DECAY: begin
            if (wStrb_q[0]) decay_q[7:0] <= wData_q[7:0];
            if (wStrb_q[1]) decay_q[15:8] <= wData_q[15:8];
          end
          `PH_ADDR_DELAY: begin
            if (wStrb_q[0]) delay_q[7:0] <= wData_q[7:0];
            if (wStrb_q[1]) delay_q[15:8] <= wData_q[15:8];
          end
          `PH_ADDR_LOWLIM: begin
            if (wStrb_q[0]) lowLim_q[7:0] <= wData_q[7:0];
            if (wStrb_q[1]) lowLim_q[15:8] <= wData_q[15:8];
          end
          `PH_ADDR_STATUS: ;
          default: bresp <= `PH_RESP_SLVERR;
        endcase
      end
    end
  end

  // read channel, one cycle after the address is taken
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `PH_RESP_OKAY;
    end else begin
      arready <= !rvalid && !(arvalid && arready);
      if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rresp  <= `PH_RESP_OKAY;
        case (araddr[`PH_ADDR_MSB:`PH_ADDR_LSB])
          `PH_ADDR_CTRL:   rdata <= {24'h000000, ctrl_q[7:0]};
          `PH_ADDR_THR:    rdata <= {16'h0000, thr_q};
          `PH_ADDR_DECAY:  rdata <= {16'h0000, decay_q};
          `PH_ADDR_DELAY:  rdata <= {16'h0000, delay_q};
          `PH_ADDR_LOWLIM: rdata <= {16'h0000, lowLim_q};
          `PH_ADDR_STATUS: rdata <= {12'h000, shownOk_q, 1'b0,
                                     sm_q, sampleOut.temp};
          default: begin
            rdata <= 32'h0000_0000;
            rresp <= `PH_RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // millisecond tick from the system clock
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tickCnt_q <= 32'h0000_0000;
    end else if (tickCnt_q == 32'(TICK_CYCLES - 1)) begin
      tickCnt_q <= 32'h0000_0000;
    end else begin
      tickCnt_q <= tickCnt_q + 32'h0000_0001;
    end
  end
  assign tick = (tickCnt_q == 32'(TICK_CYCLES - 1));

  // interval length per selector code
  always_comb begin
    case (csel)
      4'h2:    ciLen = `PH_CI_2;
      4'h3:    ciLen = `PH_CI_3;
      4'h4:    ciLen = `PH_CI_4;
      4'h5:    ciLen = `PH_CI_5;
      4'h6:    ciLen = `PH_CI_6;
      4'h7:    ciLen = `PH_CI_7;
      4'h8:    ciLen = `PH_CI_8;
      4'h9:    ciLen = `PH_CI_9;
      4'ha:    ciLen = `PH_CI_10;
      4'hb:    ciLen = `PH_CI_11;
      default: ciLen = `PH_CI_12;
    endcase
  end

  // decay step: rate in 0.01 deg/s, one step per ms tick
  assign decSum   = {7'h00, decAcc_q} + {1'b0, decay_q};
  assign decWhole = decSum / `PH_DECAY_DIV;
  assign decayed  = ({1'b0, held_q} <= ({1'b0, t} + decWhole))
                  ? t : 16'(held_q - decWhole[15:0]);

  // mode tracking for the restart on change
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      modeLast_q <= 2'b00;
    end else begin
      modeLast_q <= ctrl_q[`PH_MODE_MSB:`PH_MODE_LSB];
    end
  end

  // clear interval: running and shown buffers with the interval timer
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ciCnt_q   <= 15'h0000;
      run_q     <= `PH_RST_TEMP;
      shown_q   <= `PH_RST_TEMP;
      shownOk_q <= 1'b0;
    end else if (modeChg || !clearOn) begin
      ciCnt_q   <= 15'h0000;
      run_q     <= `PH_RST_TEMP;
      shownOk_q <= 1'b0;
    end else begin
      if (tick && (ciCnt_q >= ciLen - 15'h0001)) begin
        ciCnt_q   <= 15'h0000;
        shown_q   <= (sampleIn.valid && t > run_q) ? t : run_q;
        shownOk_q <= 1'b1;
        run_q     <= sampleIn.valid ? t : `PH_RST_TEMP;
      end else begin
        if (tick) ciCnt_q <= ciCnt_q + 15'h0001;
        if (sampleIn.valid && t > run_q) run_q <= t;
      end
    end
  end

  // smart and auto hold: held value, delay and phase
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      held_q    <= `PH_RST_TEMP;
      sm_q      <= SM_BELOW;
      dlyCnt_q  <= 14'h0000;
      decAcc_q  <= 10'h000;
      prevHot_q <= 1'b0;
    end else if (modeChg) begin
      held_q    <= t;
      sm_q      <= SM_BELOW;
      dlyCnt_q  <= 14'h0000;
      decAcc_q  <= 10'h000;
      prevHot_q <= 1'b0;
    end else if (mode == MODE_AUTO) begin
      if (sampleIn.valid) begin
        prevHot_q <= hotNow;
        if (newObj) begin
          held_q <= t;
        end else if (t > held_q) begin
          held_q <= t;
        end
      end
    end else if (mode == MODE_SMART) begin
      case (sm_q)
        SM_BELOW: begin
          held_q   <= t;
          dlyCnt_q <= 14'h0000;
          decAcc_q <= 10'h000;
          if (sampleIn.valid && t > thr_q) begin
            sm_q <= (delay_q == 16'h0000) ? SM_HOLD : SM_DELAY;
          end
        end
        SM_DELAY: begin
          held_q <= t;
          if (sampleIn.valid && t <= thr_q) begin
            sm_q <= SM_BELOW;
          end else if (tick) begin
            if (dlyCnt_q >= 14'(delay_q * `PH_DELAY_UNIT_MS) - 14'h0001) begin
              sm_q <= SM_HOLD;
            end else begin
              dlyCnt_q <= dlyCnt_q + 14'h0001;
            end
          end
        end
        SM_HOLD: begin
          if (sampleIn.valid && t <= thr_q) begin
            sm_q   <= SM_BELOW;
            held_q <= t;
          end else if (sampleIn.valid && t > held_q) begin
            held_q <= t;
          end else if (tick && decay_q != 16'h0000) begin
            held_q   <= decayed;
            decAcc_q <= 10'(decSum - decWhole * `PH_DECAY_DIV);
          end
        end
        default: sm_q <= SM_BELOW;
      endcase
    end
  end

  // output selection, registered
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sampleOut <= '0;
    end else begin
      sampleOut.valid <= sampleIn.valid;
      case (mode)
        MODE_AUTO:  sampleOut.temp <= (newObj || t > held_q) ? t : held_q;
        MODE_CLEAR: sampleOut.temp <= shownOk_q ? shown_q : t;
        MODE_SMART: sampleOut.temp <= (sm_q == SM_HOLD && t > thr_q
                                       && held_q > t) ? held_q : t;
        default:    sampleOut.temp <= t;
      endcase
    end
  end

endmodule : peak_hold_picker
`default_nettype wire

// file: sim/peak_hold_picker_asserts.sv
// checker for the peak hold picker ports.
// assumes write address and data are offered together.
`timescale 1ns/100ps
`default_nettype none
module peak_hold_picker_asserts import peak_hold_pkg::*; (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic [31:0] awaddr,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic [31:0] wdata,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [31:0] araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire sample_s     sampleIn,
  input wire sample_s     sampleOut
);
  logic [1:0]  modeQ;
  logic [3:0]  cselQ;
  logic [15:0] thrQ;
  logic [1:0]  calmQ;
  logic        wrGo;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // write handshake seen on both channels
  assign wrGo = awvalid && awready && wvalid && wready;
  // shadow of mode, selector, threshold and quiet time
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      modeQ <= 2'h0;
      cselQ <= 4'h0;
      thrQ <= 16'h0000;
      calmQ <= 2'h0;
    end else begin
      if (wrGo && awaddr[5:2] == 4'h0) begin
        modeQ <= wdata[1:0];
        cselQ <= wdata[7:4];
      end
      if (wrGo && awaddr[5:2] == 4'h1) begin
        thrQ <= wdata[15:0];
      end
      calmQ <= wrGo ? 2'h0 : (calmQ == 2'h3 ? calmQ : calmQ + 2'h1);
    end
  end
  property p_out_valid;
    sampleOut.valid == $past(sampleIn.valid);
  endproperty
  a_out_valid: assert property (p_out_valid) else $error("out strobe lag");
  property p_live;
    calmQ == 2'h3 && sampleOut.valid && (modeQ == 2'h0 ||
      (modeQ == 2'h2 && cselQ < 4'h2))
      |-> sampleOut.temp == $past(sampleIn.temp);
  endproperty
  a_live: assert property (p_live) else $error("live path differs");
  property p_below;
    calmQ == 2'h3 && sampleOut.valid && modeQ == 2'h3 &&
      $past(sampleIn.temp) <= thrQ |-> sampleOut.temp == $past(sampleIn.temp);
  endproperty
  a_below: assert property (p_below) else $error("held below threshold");
  property p_floor;
    calmQ == 2'h3 && sampleOut.valid && modeQ[0]
      |-> sampleOut.temp >= $past(sampleIn.temp);
  endproperty
  a_floor: assert property (p_floor) else $error("held under input");
  // the answer comes two edges after the taking edge
  property p_bresp;
    wrGo |-> ##2 bvalid &&
      ((bresp == 2'b10) == ($past(awaddr[5:2], 2) > 4'h5));
  endproperty
  a_bresp: assert property (p_bresp) else $error("write answer wrong");
  property p_bhold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_rresp;
    arvalid && arready |=> rvalid &&
      ((rresp == 2'b10) == ($past(araddr[5:2]) > 4'h5));
  endproperty
  a_rresp: assert property (p_rresp) else $error("read answer wrong");
  property p_rhold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  property p_noacc;
    bvalid |-> !awready && !wready;
  endproperty
  a_noacc: assert property (p_noacc) else $error("write taken too early");
endmodule : peak_hold_picker_asserts
bind peak_hold_picker peak_hold_picker_asserts u_peak_hold_picker_asserts (
  .clk_sys, .rst, .awaddr, .awvalid, .awready, .wdata, .wvalid, .wready,
  .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
  .rvalid, .rready, .sampleIn, .sampleOut);
`default_nettype wire

// file: sim/sample_source.sv
// sample source standing in for the measurement path.
// assumes put is called just after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module sample_source import peak_hold_pkg::*; (
  input wire logic clk_sys,
  output var sample_s sampleIn
);
  initial sampleIn = '0;
  // one strobe per sample, value held for n samples
  task automatic put(input logic [15:0] t, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      sampleIn <= '{valid: 1'b1, temp: t};
    end
    @(posedge clk_sys);
    sampleIn.valid <= 1'b0;
  endtask : put
endmodule : sample_source
`default_nettype wire

// file: sim/tb_peak_hold_picker.sv
// self-checking bench for the peak hold picker.
// assumes a 1 ms tick of 10 clocks, so 10 ms spans 100 clocks.
`timescale 1ns/100ps
`default_nettype none
module tb_peak_hold_picker import peak_hold_pkg::*;;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  sample_s     sampleIn, sampleOut;
  int          err_total = 0;
  int          tests_run = 0;
  // free running system clock
  always #5 clk_sys = ~clk_sys;
  peak_hold_picker #(.TICK_CYCLES(10)) u_peak_hold_picker (
    .clk_sys, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf),
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .sampleIn, .sampleOut);
  sample_source u_sample_source (.clk_sys, .sampleIn);
  task automatic give_verdict;
    if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  task automatic fail(input string m);
    err_total++;
    $display("wrong value at %0t: %s", $time, m);
  endtask : fail
  task automatic chk_bus(input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) fail("bus result");
  endtask : chk_bus
  task automatic chk_temp(input logic [15:0] got, exp);
    tests_run++;
    if (got !== exp) fail("output temperature");
  endtask : chk_temp
  task automatic chk_flag(input logic f);
    tests_run++;
    if (f !== 1'b1) fail("output out of range");
  endtask : chk_flag
  // one clock with a bound on the whole wait
  task automatic step(inout int n);
    @(posedge clk_sys);
    n++;
    if (n > 200) begin
      fail("wait ran out");
      give_verdict();
    end
  endtask : step
  task automatic wr(input logic [31:0] a, d, output logic [1:0] r);
    int n = 0;
    logic aw = 1'b1;
    logic w = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      step(n);
      if (aw && awready) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end while (aw || w || !bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n = 0;
    logic ar = 1'b1;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      step(n);
      if (ar && arready) begin
        ar = 1'b0;
        arvalid <= 1'b0;
      end
    end while (ar || !rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic cfg(input logic [31:0] a, d);
    logic [1:0] r;
    wr(a, d, r);
    chk_bus({30'h0, r}, 32'h0);
  endtask : cfg
  // send n samples of t, then look at the output
  task automatic see(input logic [15:0] t, input int n, input logic [15:0] e);
    u_sample_source.put(t, n);
    @(posedge clk_sys);
    chk_temp(sampleOut.temp, e);
  endtask : see
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    rd(32'h0, d, r);
    chk_bus(d, 32'h0);
    wr(32'h18, 32'h1, r);
    chk_bus({30'h0, r}, 32'h2);
    rd(32'h1c, d, r);
    chk_bus({r, d[29:0]}, 32'h8000_0000);
    cfg(32'h0, 32'hc2);
    rd(32'h0, d, r);
    chk_bus(d, 32'hc2);
  endtask : t_regs
  task automatic t_live;
    cfg(32'h0, 32'h02);
    see(16'h02bc, 3, 16'h02bc);
    see(16'h012c, 1, 16'h012c);
    cfg(32'h0, 32'h0);
    see(16'h0032, 1, 16'h0032);
  endtask : t_live
  task automatic t_clear;
    cfg(32'h0, 32'h22);
    see(16'h0320, 5, 16'h0320);
    see(16'h00c8, 120, 16'h0320);
    see(16'h00c8, 100, 16'h00c8);
  endtask : t_clear
  task automatic t_smart;
    logic [31:0] d;
    logic [1:0]  r;
    cfg(32'h4, 32'd1000);
    cfg(32'h8, 32'h0);
    cfg(32'hc, 32'h0);
    cfg(32'h0, 32'h3);
    see(16'd500, 2, 16'd500);
    see(16'd2000, 1, 16'd2000);
    see(16'd1500, 100, 16'd2000);
    see(16'd900, 1, 16'd900);
    cfg(32'hc, 32'h2);
    see(16'd4000, 1, 16'd4000);
    see(16'd1200, 50, 16'd1200);
    see(16'd1500, 220, 16'd1500);
    see(16'd3000, 1, 16'd3000);
    see(16'd1500, 10, 16'd3000);
    cfg(32'h8, 32'd16666);
    u_sample_source.put(16'd1500, 100);
    @(posedge clk_sys);
    chk_flag(sampleOut.temp < 16'd3000 && sampleOut.temp > 16'd2800);
    rd(32'h4, d, r);
    chk_bus(d, 32'd1000);
  endtask : t_smart
  task automatic t_auto;
    logic [31:0] d;
    logic [1:0]  r;
    cfg(32'h10, 32'd1000);
    cfg(32'h0, 32'h1);
    see(16'd2000, 1, 16'd2000);
    see(16'd1500, 3, 16'd2000);
    see(16'd500, 1, 16'd2000);
    see(16'd1050, 1, 16'd2000);
    see(16'd1200, 1, 16'd1200);
    // status: shown flag clear, phase below, output temperature
    rd(32'h14, d, r);
    chk_bus(d, 32'h0000_04b0);
  endtask : t_auto
  // reset, then every scenario in turn
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_regs();
    t_live();
    t_clear();
    t_smart();
    t_auto();
    give_verdict();
  end
endmodule : tb_peak_hold_picker
`default_nettype wire
